// ---- bsr_top.sv ----
`timescale 1ns/1ns
module bsr_top
(
  input  wire logic        clk_in,
  input  wire logic        rst_b_in,
  input  wire logic        ce_in,
  // register port
  input  wire logic [15:0] reg_addr_in,
  input  wire logic [7:0]  reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic      [7:0]  reg_rdata_out,
  // cpu side
  input  wire logic [15:0] cpu_addr_in,
  input  wire logic        cpu_fetch_in,
  input  wire logic        instr_done_in,
  input  wire logic        wait_state_in,
  input  wire logic        stop_state_in,
  input  wire logic        break_state_in,
  output logic             break_req_out,
  output logic             clear_allow_out,
  output logic             irq_out
);
  import bsr_pkg::*;

  // ----------------------------------------------------------------
  // state and decode
  // ----------------------------------------------------------------
  bsr_state_t st_q;
  bsr_state_t st_d;

  logic       wr_wake;
  logic       wr_flag;
  logic       wr_high;
  logic       wr_low;
  logic       wr_brk;
  logic       wr_istat;
  logic       wr_imask;
  logic       match;
  logic       raise;
  logic       wake_set;
  logic       low_power;
  logic       clr_ok;
  logic [1:0] ev;
  logic [7:0] rd_mux;

  // write strobes per register
  assign wr_wake  = reg_wr_in && (reg_addr_in == BSR_OFS_WAKE_STAT);
  assign wr_flag  = reg_wr_in && (reg_addr_in == BSR_OFS_FLAG_CTRL);
  assign wr_high  = reg_wr_in && (reg_addr_in == BSR_OFS_ADDR_HIGH);
  assign wr_low   = reg_wr_in && (reg_addr_in == BSR_OFS_ADDR_LOW);
  assign wr_brk   = reg_wr_in && (reg_addr_in == BSR_OFS_BRK_CTRL);
  assign wr_istat = reg_wr_in && (reg_addr_in == BSR_OFS_IRQ_STAT);
  assign wr_imask = reg_wr_in && (reg_addr_in == BSR_OFS_IRQ_MASK);

  // ----------------------------------------------------------------
  // breakpoint detection
  // ----------------------------------------------------------------
  // only program-counter addresses count, not data accesses
  assign match = st_q.brk_enable && cpu_fetch_in
                 && (cpu_addr_in == {st_q.addr_high, st_q.addr_low});

  // the break itself waits for the instruction boundary;
  // a match on the last cycle of an instruction goes at once
  assign raise = (st_q.brk_pending || match) && instr_done_in;

  // a break taken while the core sleeps is what wakes it
  assign low_power = wait_state_in || stop_state_in;
  assign wake_set  = raise && low_power;

  // outside break every clear goes through
  assign clr_ok = !break_state_in || st_q.clear_enable;

  assign ev = {wake_set, raise};

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  always_comb
  begin
    rd_mux = BSR_RST_DATA;
    case (reg_addr_in)
      BSR_OFS_WAKE_STAT:
      begin
        rd_mux[BSR_BIT_WAKE_FLAG] = st_q.wake_flag;
      end
      BSR_OFS_FLAG_CTRL:
      begin
        rd_mux[BSR_BIT_CLEAR_ENABLE] = st_q.clear_enable;
      end
      BSR_OFS_ADDR_HIGH:
      begin
        rd_mux = st_q.addr_high;
      end
      BSR_OFS_ADDR_LOW:
      begin
        rd_mux = st_q.addr_low;
      end
      BSR_OFS_BRK_CTRL:
      begin
        rd_mux[BSR_BIT_BRK_ENABLE] = st_q.brk_enable;
        rd_mux[BSR_BIT_BRK_ACTIVE] = st_q.brk_active;
      end
      BSR_OFS_IRQ_STAT:
      begin
        rd_mux[1:0] = st_q.irq_stat;
      end
      BSR_OFS_IRQ_MASK:
      begin
        rd_mux[1:0] = st_q.irq_mask;
      end
      default:
      begin
        rd_mux = BSR_RST_DATA; // unmapped reads as zero
      end
    endcase
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    st_d = st_q;

    // address bytes, plain read/write
    if (wr_high)
    begin
      st_d.addr_high = reg_wdata_in;
    end
    if (wr_low)
    begin
      st_d.addr_low = reg_wdata_in;
    end

    // only bit 7 is stored; reserved bits drop
    if (wr_flag)
    begin
      st_d.clear_enable = reg_wdata_in[BSR_BIT_CLEAR_ENABLE];
    end

    // break control: enable is plain, active is a status that
    // software may also set to force a break
    if (wr_brk)
    begin
      st_d.brk_enable = reg_wdata_in[BSR_BIT_BRK_ENABLE];
      st_d.brk_active = reg_wdata_in[BSR_BIT_BRK_ACTIVE];
    end
    if (wr_brk && reg_wdata_in[BSR_BIT_BRK_ACTIVE])
    begin
      st_d.brk_pending = 1'b1;
    end

    // a match is held until the instruction ends
    if (match)
    begin
      st_d.brk_pending = 1'b1;
      st_d.brk_active  = 1'b1;
    end
    if (raise)
    begin
      st_d.brk_pending = 1'b0;
    end

    // wake flag: write 0 clears, but during break only when
    // clears are enabled; a set in the same cycle wins
    if (wr_wake && !reg_wdata_in[BSR_BIT_WAKE_FLAG] && clr_ok)
    begin
      st_d.wake_flag = 1'b0;
    end
    if (wake_set)
    begin
      st_d.wake_flag = 1'b1;
    end

    // interrupt status: write one to clear, events win
    if (wr_istat)
    begin
      st_d.irq_stat = st_q.irq_stat & ~reg_wdata_in[1:0];
    end
    st_d.irq_stat = st_d.irq_stat | ev;
    if (wr_imask)
    begin
      st_d.irq_mask = reg_wdata_in[1:0];
    end

    // registered outputs
    st_d.rd_data     = reg_rd_in ? rd_mux : BSR_RST_DATA;
    st_d.brk_req     = raise;
    st_d.irq         = |(st_d.irq_stat & st_d.irq_mask);
    st_d.clear_allow = clr_ok;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (!rst_b_in)
    begin
      st_q              <= '0;
      st_q.addr_high    <= BSR_RST_ADDR_BYTE;
      st_q.addr_low     <= BSR_RST_ADDR_BYTE;
      st_q.wake_flag    <= 1'b0;
      st_q.clear_enable <= 1'b0;
      st_q.irq_stat     <= BSR_RST_IRQ;
      st_q.irq_mask     <= BSR_RST_IRQ;
      st_q.clear_allow  <= 1'b1;
    end
    else if (ce_in)
    begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all from flip-flops
  // ----------------------------------------------------------------
  assign reg_rdata_out   = st_q.rd_data;
  assign break_req_out   = st_q.brk_req;
  assign clear_allow_out = st_q.clear_allow;
  assign irq_out         = st_q.irq;

endmodule

// ---- bsr_pkg.sv ----
// Behaviour
// - breakpoint address held as high byte (15:8) and low byte (7:0), read/write
// - reset clears both breakpoint address bytes to zero
// - break that ends wait or stop sets the break-wakeup flag
// - writing 0 clears the break-wakeup flag; reset clears it; always readable (in break state the code clears it only when clear enable is 1)
// - in break state, status clears elsewhere allowed only when clear enable is 1
// - break clear enable is bit 7 of flag control, resets 0, rest reserved
// - enabled address match signals breakpoint, taken when instruction completes
// - writing 1 to break active raises a break like an address match
package bsr_pkg;

  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [15:0] BSR_OFS_WAKE_STAT = 16'hFE00;
  localparam logic [15:0] BSR_OFS_FLAG_CTRL = 16'hFE03;
  localparam logic [15:0] BSR_OFS_ADDR_HIGH = 16'hFE0C;
  localparam logic [15:0] BSR_OFS_ADDR_LOW  = 16'hFE0D;
  localparam logic [15:0] BSR_OFS_BRK_CTRL  = 16'hFE0E;
  localparam logic [15:0] BSR_OFS_IRQ_STAT  = 16'hFE10;
  localparam logic [15:0] BSR_OFS_IRQ_MASK  = 16'hFE11;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int BSR_BIT_WAKE_FLAG    = 1;
  localparam int BSR_BIT_CLEAR_ENABLE = 7;
  localparam int BSR_BIT_BRK_ENABLE   = 7;
  localparam int BSR_BIT_BRK_ACTIVE   = 6;
  localparam int BSR_IRQ_BIT_BREAK    = 0;
  localparam int BSR_IRQ_BIT_WAKE     = 1;

  // ----------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------
  localparam logic [7:0] BSR_RST_ADDR_BYTE = 8'h00;
  localparam logic [7:0] BSR_RST_DATA      = 8'h00;
  localparam logic [1:0] BSR_RST_IRQ       = 2'h0;

  // ----------------------------------------------------------------
  // state of the block
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr_high;
    logic [7:0] addr_low;
    logic       clear_enable;
    logic       brk_enable;
    logic       brk_active;
    logic       brk_pending;
    logic       wake_flag;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic [7:0] rd_data;
    logic       brk_req;
    logic       irq;
    logic       clear_allow;
  } bsr_state_t;

endpackage

// ---- bsr_assertions.sv ----
`timescale 1ns/1ns
// ----------------------------------------
// port checks
// ----------------------------------------
module bsr_assertions
  import bsr_pkg::*;
(
  input wire logic        clk_in,
  input wire logic        rst_b_in,
  input wire logic [15:0] reg_addr_in,
  input wire logic [7:0]  reg_wdata_in,
  input wire logic        reg_wr_in,
  input wire logic        reg_rd_in,
  input wire logic [7:0]  reg_rdata_out,
  input wire logic        instr_done_in,
  input wire logic        break_state_in,
  input wire logic        break_req_out,
  input wire logic        clear_allow_out,
  input wire logic        irq_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);
  // write then read of one address
  sequence wr_rd(logic [15:0] a);
    reg_wr_in && reg_addr_in == a ##1 reg_rd_in && reg_addr_in == a;
  endsequence
  // software break: write, then instruction end
  sequence force_brk;
    reg_wr_in && reg_addr_in == BSR_OFS_BRK_CTRL && reg_wdata_in[6]
    ##1 instr_done_in;
  endsequence
  chk_addr_high_rw: assert property (
    wr_rd(BSR_OFS_ADDR_HIGH) |=> reg_rdata_out == $past(reg_wdata_in, 2))
    else $error("high byte read-back wrong");
  chk_addr_low_rw: assert property (
    wr_rd(BSR_OFS_ADDR_LOW) |=> reg_rdata_out == $past(reg_wdata_in, 2))
    else $error("low byte read-back wrong");
  chk_reset_quiet: assert property (
    $rose(rst_b_in) |-> !break_req_out && !irq_out && reg_rdata_out == 8'h00)
    else $error("outputs busy after reset");
  chk_stat_reserved: assert property (
    reg_rd_in && reg_addr_in == BSR_OFS_WAKE_STAT
    |=> (reg_rdata_out & 8'hFD) == 8'h00)
    else $error("wake status spare bits set");
  chk_ctrl_reserved: assert property (
    reg_rd_in && reg_addr_in == BSR_OFS_FLAG_CTRL |=> reg_rdata_out[6:0] == 7'h00)
    else $error("flag control spare bits set");
  chk_clear_permit: assert property (
    !break_state_in |=> clear_allow_out)
    else $error("clear blocked outside break");
  chk_break_cause: assert property (
    break_req_out |-> $past(instr_done_in))
    else $error("break raised mid instruction");
  chk_force_break: assert property (
    force_brk |=> break_req_out)
    else $error("software break not raised");
endmodule
bind bsr_top bsr_assertions i_chk
(
  .clk_in(clk_in), .rst_b_in(rst_b_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out), .instr_done_in(instr_done_in),
  .break_state_in(break_state_in), .break_req_out(break_req_out),
  .clear_allow_out(clear_allow_out), .irq_out(irq_out)
);

// ---- bsr_cpu_model.sv ----
`timescale 1ns/1ns
// ----------------------------------------
// core stand-in
// ----------------------------------------
module bsr_cpu_model
(
  input  wire logic        clk_in,
  input  wire logic        rst_b_in,
  input  wire logic [1:0]  sleep_in,
  input  wire logic        rti_in,
  input  wire logic        break_req_in,
  output logic      [15:0] addr_out,
  output logic             fetch_out,
  output logic             done_out,
  output logic      [1:0]  low_pwr_out,
  output logic             brk_out
);
  logic [15:0] pc_q;
  logic [1:0]  cyc_q;
  logic        run;
  // three-cycle instructions; asleep counts as finished
  assign run       = !brk_out && low_pwr_out == 2'h0;
  assign fetch_out = run && cyc_q == 2'h0;
  assign done_out  = !brk_out && (cyc_q == 2'h2 || !run);
  // operand cycles show other addresses, never a stale fetch
  assign addr_out  = fetch_out ? pc_q : ~pc_q;
  // a break wakes the core and parks it until return
  always_ff @(posedge clk_in)
  begin
    if (!rst_b_in || break_req_in || cyc_q == 2'h2 || !run)
      cyc_q <= 2'h0;
    else
      cyc_q <= cyc_q + 2'h1;
    pc_q <= !rst_b_in ? 16'h8000 : pc_q + {15'h0, run && cyc_q == 2'h2};
    if (!rst_b_in || break_req_in)
      low_pwr_out <= 2'h0;
    else if (sleep_in != 2'h0)
      low_pwr_out <= sleep_in;
    brk_out <= rst_b_in && !rti_in && (brk_out || break_req_in);
  end
endmodule

// ---- test_breakpoint_status_regs.sv ----
`timescale 1ns/1ns
module test_breakpoint_status_regs;
  import bsr_pkg::*;
  logic        clk_in = 1'b0;
  logic        rst_b_in = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [7:0]  wdata = 8'h00;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [1:0]  sleep = 2'h0;
  logic        rti = 1'b0;
  logic [15:0] cpu_a;
  logic [7:0]  rdata;
  logic [1:0]  lp;
  logic        fetch, done, brk_st, brk_req, clr_ok, irq;
  int          bad_count = 0;
  int          n_tests = 0;
  int          cycles = 0;
  // 250 MHz
  always #2 clk_in = ~clk_in;
  bsr_top i_dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .ce_in(1'b1),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_rdata_out(rdata), .cpu_addr_in(cpu_a),
    .cpu_fetch_in(fetch), .instr_done_in(done), .wait_state_in(lp[0]),
    .stop_state_in(lp[1]), .break_state_in(brk_st), .break_req_out(brk_req),
    .clear_allow_out(clr_ok), .irq_out(irq));
  bsr_cpu_model i_cpu (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .sleep_in(sleep), .rti_in(rti), .break_req_in(brk_req),
    .addr_out(cpu_a), .fetch_out(fetch), .done_out(done),
    .low_pwr_out(lp), .brk_out(brk_st));
  task automatic chk(input logic ok, input string m);
    n_tests++;
    if (!ok)
    begin
      bad_count++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  // strobes drop after one cycle, so back-to-back calls leave a gap
  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    #1 chk(rdata === e, "read data");
  endtask
  // write then read with no gap, so the read-back checks see it
  task automatic wr_rd_chk(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    #1 chk(rdata === d, "write-read data");
  endtask
  task automatic wait_brk(input int lim);
    for (int i = 0; i < lim && brk_req !== 1'b1; i++)
      @(posedge clk_in) #1;
    chk(brk_req === 1'b1, "no break");
  endtask
  task automatic cpu_rti();
    @(posedge clk_in);
    rti <= 1'b1;
    @(posedge clk_in);
    rti <= 1'b0;
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // hang guard, well past the expected run
  always @(posedge clk_in)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      bad_count++;
      give_verdict();
    end
  end
  initial
  begin
    repeat (16) @(posedge clk_in);
    rst_b_in <= 1'b1;
    rd_chk(BSR_OFS_ADDR_HIGH, 8'h00);
    rd_chk(BSR_OFS_ADDR_LOW, 8'h00);
    rd_chk(BSR_OFS_FLAG_CTRL, 8'h00);
    wr_rd_chk(BSR_OFS_ADDR_HIGH, 8'h5A);
    wr_rd_chk(BSR_OFS_ADDR_LOW, 8'hA5);
    wr_reg(BSR_OFS_ADDR_HIGH, 8'h80);
    wr_reg(BSR_OFS_ADDR_LOW, 8'h40);
    rd_chk(BSR_OFS_ADDR_HIGH, 8'h80);
    rd_chk(BSR_OFS_ADDR_LOW, 8'h40);
    wr_reg(BSR_OFS_FLAG_CTRL, 8'hFF);
    rd_chk(BSR_OFS_FLAG_CTRL, 8'h80);
    wr_reg(BSR_OFS_FLAG_CTRL, 8'h00);
    rd_chk(16'hFE01, 8'h00);
    $display("registers done");
    wr_reg(BSR_OFS_IRQ_MASK, 8'h01);
    wr_reg(BSR_OFS_BRK_CTRL, 8'h80);
    wait_brk(400);
    rd_chk(BSR_OFS_BRK_CTRL, 8'hC0);
    chk(clr_ok === 1'b0 && irq === 1'b1, "break state");
    wr_reg(BSR_OFS_FLAG_CTRL, 8'h80);
    @(posedge clk_in) #1 chk(clr_ok === 1'b1, "clear blocked");
    wr_reg(BSR_OFS_BRK_CTRL, 8'h00);
    cpu_rti();
    wr_reg(BSR_OFS_IRQ_MASK, 8'h00);
    @(posedge clk_in) #1 chk(irq === 1'b0, "masked irq");
    wr_reg(BSR_OFS_IRQ_STAT, 8'h01);
    rd_chk(BSR_OFS_IRQ_STAT, 8'h00);
    $display("address break done");
    // wait, then stop
    for (int m = 1; m < 3; m++)
    begin
      @(posedge clk_in);
      sleep <= 2'(m);
      @(posedge clk_in);
      sleep <= 2'h0;
      wr_reg(BSR_OFS_BRK_CTRL, 8'h40);
      wait_brk(8);
      rd_chk(BSR_OFS_WAKE_STAT, 8'h02);
      wr_reg(BSR_OFS_FLAG_CTRL, 8'h00);
      wr_reg(BSR_OFS_WAKE_STAT, 8'h00);
      rd_chk(BSR_OFS_WAKE_STAT, 8'h02);
      wr_reg(BSR_OFS_FLAG_CTRL, 8'h80);
      wr_reg(BSR_OFS_WAKE_STAT, 8'h00);
      rd_chk(BSR_OFS_WAKE_STAT, 8'h00);
      wr_reg(BSR_OFS_BRK_CTRL, 8'h00);
      cpu_rti();
    end
    // wake event also left its interrupt status bit behind
    wr_reg(BSR_OFS_IRQ_MASK, 8'h02);
    @(posedge clk_in) #1 chk(irq === 1'b1, "wake irq");
    wr_reg(BSR_OFS_IRQ_STAT, 8'h03);
    @(posedge clk_in) #1 chk(irq === 1'b0, "wake irq clear");
    $display("wake tests done");
    give_verdict();
  end
endmodule
